// ===== src/sbp_defs.svh
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH

// register indices; byte address is four times the index
`define SBP_ADDR_W 12
`define SBP_DATA_IDX 12'h060
`define SBP_CTRL_IDX 12'h061
`define SBP_DATA_ADDR (`SBP_DATA_IDX << 2)
`define SBP_CTRL_ADDR (`SBP_CTRL_IDX << 2)

// control register fields
`define SBP_DONE_BIT 7
`define SBP_TBF_BIT 6
`define SBP_MODE_MSB 5
`define SBP_MODE_LSB 4
`define SBP_CLOCK_POLARITY_SEL_BIT 3
`define SBP_CLOCK_PHASE_SEL_BIT 2
`define SBP_RATE_MSB 1
`define SBP_CTRL_RST 8'h00

// mode codes
`define SBP_MODE_DIS 2'b00
`define SBP_MODE_MASTER 2'b01
`define SBP_MODE_SLAVE 2'b10

// axi responses
`define SBP_RESP_OKAY 2'b00
`define SBP_RESP_SLVERR 2'b10

// timing: system clock and the four master bit rates
`define SBP_CLK_HZ 100000000
`define SBP_RATE0_BPS 2000000
`define SBP_RATE1_BPS 1000000
`define SBP_RATE2_BPS 500000
`define SBP_RATE3_BPS 62500
`define SBP_BIT_CYC0 (`SBP_CLK_HZ / `SBP_RATE0_BPS)
`define SBP_BIT_CYC1 (`SBP_CLK_HZ / `SBP_RATE1_BPS)
`define SBP_BIT_CYC2 (`SBP_CLK_HZ / `SBP_RATE2_BPS)
`define SBP_BIT_CYC3 (`SBP_CLK_HZ / `SBP_RATE3_BPS)
`define SBP_DUTY_DIV_FAST 3
`define SBP_DUTY_DIV 2
`define SBP_LAST_BIT 4'd7

`endif

// ===== src/sbp_pkg.sv
`include "sbp_defs.svh"

package sbp_pkg;

    typedef enum logic [1:0] {SEL_NONE, SEL_DATA, SEL_CTRL} sbp_sel_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic [`SBP_ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [7:0] wdata;
        logic wlane;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [1:0] mode;
        logic clock_polarity_sel;
        logic clock_phase_sel;
        logic [1:0] rate;
        logic done;
        logic tx_buffer_full;
        logic [7:0] txbuf;
        logic [7:0] rxbuf;
        logic [7:0] sh;
        logic lat;
        logic busy;
        logic [3:0] bits;
        logic [10:0] cnt;
        logic [3:0] lead_cnt;
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic ss_s1;
        logic ss_s2;
        logic ss_d;
        logic mosi_s1;
        logic mosi_s2;
        logic miso_s1;
        logic miso_s2;
    } sbp_state_t;

endpackage

// ===== src/sbp_spi_port.sv
// Decided for this implementation: the AXI4-Lite slave port.
`include "sbp_defs.svh"

module sbp_spi_port (
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`SBP_ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`SBP_ADDR_W-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // spi pins
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic ss_n_in,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    // completion request, follows the done flag
    output logic spi_irq
);
    import sbp_pkg::*;

    sbp_state_t q;
    sbp_state_t s;
    logic do_wr;
    logic wr_data;
    logic wr_ctrl;
    logic lead;
    logic trail;
    logic byte_end;
    logic load;
    logic out_upd;
    logic out_bit;
    logic master;
    logic slave;
    logic ss_act;
    logic sdi;
    logic [10:0] per;
    logic [10:0] hi;
    logic [7:0] sh_n;
    sbp_sel_t wsel;
    sbp_sel_t rsel;

    // address decode shared by both bus directions
    function automatic sbp_sel_t reg_sel(input logic [`SBP_ADDR_W-1:0] a);
        if (a == `SBP_DATA_ADDR) begin
            return SEL_DATA;
        end else if (a == `SBP_CTRL_ADDR) begin
            return SEL_CTRL;
        end
        return SEL_NONE;
    endfunction

    // bit period in system cycles per rate code
    function automatic logic [10:0] per_len(input logic [1:0] r);
        case (r)
            2'd0: return 11'(`SBP_BIT_CYC0);
            2'd1: return 11'(`SBP_BIT_CYC1);
            2'd2: return 11'(`SBP_BIT_CYC2);
            default: return 11'(`SBP_BIT_CYC3);
        endcase
    endfunction

    // active clock time per bit; a third at the fastest rate
    function automatic logic [10:0] hi_len(input logic [1:0] r);
        if (r == 2'd0) begin
            return 11'(per_len(r) / 11'(`SBP_DUTY_DIV_FAST));
        end
        return 11'(per_len(r) / 11'(`SBP_DUTY_DIV));
    endfunction

    // next-state logic for the whole block
    always_comb begin
        s = q;
        do_wr = 1'b0;
        wr_data = 1'b0;
        wr_ctrl = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        byte_end = 1'b0;
        load = 1'b0;
        out_upd = 1'b0;
        out_bit = 1'b0;
        wsel = SEL_NONE;
        rsel = SEL_NONE;
        sh_n = q.sh;
        master = (q.mode == `SBP_MODE_MASTER);
        slave = (q.mode == `SBP_MODE_SLAVE);
        ss_act = ~q.ss_s2;
        sdi = master ? q.miso_s2 : q.mosi_s2;
        per = per_len(q.rate);
        hi = hi_len(q.rate);

        // two-stage synchronisers; the link clock is just another input
        s.sck_s1 = sck_in;
        s.sck_s2 = q.sck_s1;
        s.sck_d = q.sck_s2;
        s.ss_s1 = ss_n_in;
        s.ss_s2 = q.ss_s1;
        s.ss_d = q.ss_s2;
        s.mosi_s1 = mosi_in;
        s.mosi_s2 = q.mosi_s1;
        s.miso_s1 = miso_in;
        s.miso_s2 = q.miso_s1;

        // write address and data are taken in either order
        if (s_axi_awvalid && q.awready) begin
            s.aw_got = 1'b1;
            s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            s.w_got = 1'b1;
            s.wdata = s_axi_wdata[7:0];
            s.wlane = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready) begin
            s.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            do_wr = 1'b1;
            wsel = reg_sel(s.aw_addr);
            s.aw_got = 1'b0;
            s.w_got = 1'b0;
            s.bvalid = 1'b1;
            s.bresp = (wsel == SEL_NONE) ? `SBP_RESP_SLVERR : `SBP_RESP_OKAY;
            wr_data = (wsel == SEL_DATA) && s.wlane;
            wr_ctrl = (wsel == SEL_CTRL) && s.wlane;
        end
        s.awready = ~s.aw_got & ~s.bvalid;
        s.wready = ~s.w_got & ~s.bvalid;

        // control write first so a same-cycle byte end still sets done
        if (wr_ctrl) begin
            s.mode = s.wdata[`SBP_MODE_MSB:`SBP_MODE_LSB];
            s.clock_polarity_sel = s.wdata[`SBP_CLOCK_POLARITY_SEL_BIT];
            s.clock_phase_sel = s.wdata[`SBP_CLOCK_PHASE_SEL_BIT];
            s.rate = s.wdata[`SBP_RATE_MSB:0];
            if (!s.wdata[`SBP_DONE_BIT]) begin
                s.done = 1'b0;
            end
        end

        // master: divider paces the bits, start only from a buffered write
        if (master) begin
            if (q.busy) begin
                if (q.cnt == per - 11'd1) begin
                    s.cnt = 11'd0;
                    trail = 1'b1;
                end else begin
                    s.cnt = q.cnt + 11'd1;
                    lead = (s.cnt == per - hi);
                end
            end else if (q.tx_buffer_full) begin
                load = 1'b1;
            end
        end else if (slave) begin
            // slave path follows the synchronised link clock; select high drops the byte in flight
            if (!ss_act) begin
                s.busy = 1'b0;
                s.bits = 4'd0;
            end else if (q.ss_d) begin
                load = 1'b1;
            end else begin
                lead = (q.sck_s2 != q.sck_d) && (q.sck_s2 != q.clock_polarity_sel);
                trail = (q.sck_s2 != q.sck_d) && (q.sck_s2 == q.clock_polarity_sel);
                if (!q.busy && q.tx_buffer_full && !lead && !trail) begin
                    load = 1'b1;
                end
            end
        end

        // buffered byte enters the shifter
        if (load) begin
            s.sh = q.txbuf;
            s.tx_buffer_full = 1'b0;
            s.bits = 4'd0;
            s.lead_cnt = 4'd0;
            out_upd = 1'b1;
            out_bit = q.txbuf[7];
            if (master) begin
                s.busy = 1'b1;
                s.cnt = 11'd0;
            end
        end

        // leading edge: phase 0 samples, phase 1 drives
        if (lead) begin
            s.busy = 1'b1;
            s.lead_cnt = q.lead_cnt + 4'd1;
            if (!q.clock_phase_sel) begin
                s.lat = sdi;
            end else begin
                out_upd = 1'b1;
                out_bit = q.sh[7];
            end
        end

        // trailing edge: shift one bit, msb first
        if (trail) begin
            sh_n = q.clock_phase_sel ? {q.sh[6:0], sdi} : {q.sh[6:0], q.lat};
            s.sh = sh_n;
            s.bits = q.bits + 4'd1;
            if (!q.clock_phase_sel) begin
                out_upd = 1'b1;
                out_bit = sh_n[7];
            end
            if (q.bits == `SBP_LAST_BIT) begin
                byte_end = 1'b1;
                s.rxbuf = sh_n;
                s.busy = 1'b0;
                s.bits = 4'd0;
                s.done = 1'b1;
            end
        end
        if (out_upd) begin
            if (master) begin
                s.mosi_o = out_bit;
            end else begin
                s.miso_o = out_bit;
            end
        end

        // data write after the load: a fresh byte waits, a waiting one is replaced
        if (wr_data) begin
            s.txbuf = s.wdata;
            s.tx_buffer_full = 1'b1;
        end

        // any mode change drops a byte in flight rather than finish it half-set
        if (s.mode != q.mode) begin
            s.busy = 1'b0;
            s.bits = 4'd0;
            s.cnt = 11'd0;
        end

        // pin drive; clock active only inside the high part of a master bit
        s.sck_o = s.clock_polarity_sel;
        if (s.mode == `SBP_MODE_MASTER && s.busy && s.cnt >= per - hi) begin
            s.sck_o = ~s.clock_polarity_sel;
        end
        s.sck_oe = (s.mode == `SBP_MODE_MASTER);
        s.mosi_oe = (s.mode == `SBP_MODE_MASTER);
        s.miso_oe = (s.mode == `SBP_MODE_SLAVE) && ~q.ss_s2;

        // read channel, one word per address
        if (q.rvalid && s_axi_rready) begin
            s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            rsel = reg_sel(s_axi_araddr);
            s.rvalid = 1'b1;
            s.rresp = `SBP_RESP_OKAY;
            case (rsel)
                SEL_DATA: s.rdata = q.rxbuf;
                SEL_CTRL: s.rdata = {q.done, q.tx_buffer_full, q.mode, q.clock_polarity_sel, q.clock_phase_sel, q.rate};
                default: begin
                    s.rdata = 8'h00;
                    s.rresp = `SBP_RESP_SLVERR;
                end
            endcase
        end
        s.arready = ~s.rvalid;
    end

    // state register; reset leaves the port disabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= s;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = {24'h000000, q.rdata};
    assign s_axi_rresp = q.rresp;
    assign sck_out = q.sck_o;
    assign sck_oe = q.sck_oe;
    assign mosi_out = q.mosi_o;
    assign mosi_oe = q.mosi_oe;
    assign miso_out = q.miso_o;
    assign miso_oe = q.miso_oe;
    assign spi_irq = q.done;

    // checks on the shifter and registers
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_master_load;
        master && !q.busy && q.tx_buffer_full && !wr_ctrl;
    endsequence

    sequence s_shift_start;
        q.busy && q.bits == 4'd0 && q.sh == $past(q.txbuf) && q.sck_o == q.clock_polarity_sel;
    endsequence

    a_master_start: assert property (s_master_load |=> s_shift_start)
        else $error("master did not start the buffered byte");

    a_rx_copy: assert property (byte_end |=> q.rxbuf == $past(sh_n))
        else $error("receive buffer missed the byte");

    a_done_irq: assert property (byte_end |=> q.done && spi_irq)
        else $error("done flag or irq not raised at byte end");

    a_tbf_write: assert property (wr_data |=> q.tx_buffer_full && q.txbuf == $past(s.wdata))
        else $error("data write did not fill the buffer");

    a_eight_pulse: assert property (master && byte_end |-> q.lead_cnt == 4'd8)
        else $error("master byte without eight clock pulses");

    a_sck_duty: assert property ((master && q.busy && $stable(q.rate) && $stable(q.clock_polarity_sel))
        |-> ((q.sck_o != q.clock_polarity_sel) == (q.cnt >= per - hi)))
        else $error("master clock high time wrong");

    a_sck_idle: assert property (!q.busy |-> q.sck_o == q.clock_polarity_sel)
        else $error("clock not at idle level");

    a_slave_hold: assert property (slave && q.ss_s2 && q.tx_buffer_full |=> q.tx_buffer_full)
        else $error("slave moved byte without select");

    a_slave_abort: assert property (slave && q.ss_s2 && !q.done |=> !q.done)
        else $error("slave completed without select");

    a_ss_reload: assert property (slave && !q.ss_s2 && q.ss_d && !wr_ctrl
        |=> q.sh == $past(q.txbuf) && q.bits == 4'd0)
        else $error("select assertion did not reload shifter");

    a_ctrl_layout: assert property (s_axi_arvalid && q.arready
        && reg_sel(s_axi_araddr) == SEL_CTRL
        |=> q.rdata == $past({q.done, q.tx_buffer_full, q.mode, q.clock_polarity_sel, q.clock_phase_sel, q.rate}))
        else $error("control read layout wrong");

    a_disabled_idle: assert property (!master && !slave |-> !q.busy && !q.sck_oe)
        else $error("disabled port is active");

endmodule // sbp_spi_port

// ===== dv/sbp_spi_partner.sv
// far side of the spi pins: a mode-0 slave for master mode, a master for slave mode
module sbp_spi_partner (
    // partner as slave
    input wire logic sck_m,
    input wire logic mosi_m,
    input wire logic sel_n,
    output logic miso_m,
    // partner as master
    output logic sck_s,
    output logic ss_n_s,
    output logic mosi_s,
    input wire logic miso_s
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx_sh = 8'h3c;
    logic [7:0] rx_sh = 8'h00;
    initial begin
        sck_s = 1'b0;
        ss_n_s = 1'b1;
        mosi_s = 1'b0;
    end
    // sample on rise, next bit on fall; select is a bench gpio, not the block's
    always @(posedge sck_m) if (!sel_n) rx_sh <= {rx_sh[6:0], mosi_m};
    always @(negedge sck_m) if (!sel_n) tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
    // deselected line floats: show the inverse so stale data never matches
    assign miso_m = sel_n ? ~tx_sh[7] : tx_sh[7];
    // one frame at 125 ns per bit; the clock stands still between frames
    task automatic send(input logic [7:0] b, input int nbits, output logic [7:0] r);
        ss_n_s = 1'b0;
        mosi_s = b[7];
        #125;
        for (int i = 0; i < nbits; i++) begin
            sck_s = 1'b1;
            r = {r[6:0], miso_s};
            #62.5;
            sck_s = 1'b0;
            b = b << 1;
            mosi_s = b[7];
            #62.5;
        end
        ss_n_s = 1'b1;
        mosi_s = ~mosi_s;
    endtask
endmodule // sbp_spi_partner

// ===== dv/test_spi_master_slave_byte_port.sv
`include "sbp_defs.svh"

module test_spi_master_slave_byte_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, sel_n = 1'b1;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rdat;
    logic awr, wrdy, bv, arr, rv, irq, clock_polarity_sel_cur = 1'b0, act_d = 1'b0;
    logic [1:0] br, rr;
    logic sck_o, sck_e, mosi_o, mosi_e, miso_o, miso_e, p_sck, p_ss, p_mosi, p_miso;
    logic [7:0] got;
    int num_errors = 0, n_tests = 0, rises = 0, act_len = 0, hi = 0;
    int cyc[4] = '{`SBP_BIT_CYC0, `SBP_BIT_CYC1, `SBP_BIT_CYC2, `SBP_BIT_CYC3};
    localparam logic [11:0] DA = `SBP_DATA_ADDR;
    localparam logic [11:0] CA = `SBP_CTRL_ADDR;
    localparam logic [1:0] OK = `SBP_RESP_OKAY;
    localparam logic [1:0] ER = `SBP_RESP_SLVERR;

    always #5 aclk = ~aclk;

    sbp_spi_port sbp_spi_port_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .sck_in(p_sck), .sck_out(sck_o), .sck_oe(sck_e), .ss_n_in(p_ss),
        .mosi_in(p_mosi), .mosi_out(mosi_o), .mosi_oe(mosi_e),
        .miso_in(p_miso), .miso_out(miso_o), .miso_oe(miso_e), .spi_irq(irq)
    );

    // undriven pins show the inverse of their last value; port bits assumed set to one
    sbp_spi_partner sbp_spi_partner_i (
        .sck_m(sck_e ? sck_o : ~sck_o), .mosi_m(mosi_e ? mosi_o : ~mosi_o),
        .sel_n(sel_n), .miso_m(p_miso), .sck_s(p_sck), .ss_n_s(p_ss),
        .mosi_s(p_mosi), .miso_s(miso_e ? miso_o : ~miso_o)
    );

    // leading edges and active length of the master clock
    always @(posedge aclk) begin
        act_d <= sck_o ^ clock_polarity_sel_cur;
        if ((sck_o ^ clock_polarity_sel_cur) && !act_d) rises <= rises + 1;
        act_len <= (sck_o ^ clock_polarity_sel_cur) ? act_len + 1 : 0;
        if (!(sck_o ^ clock_polarity_sel_cur) && act_d) hi <= act_len;
    end

    task automatic results();
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic tmo();
        num_errors++;
        results();
    endtask

    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
        n_tests++;
        if (seen !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, seen);
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        for (int n = 0; n <= 50; n++) begin
            if (n == 50) tmo();
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        chk("bresp", br, er);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
        ara <= a;
        arv <= 1'b1;
        for (int n = 0; n <= 50; n++) begin
            if (n == 50) tmo();
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        chk("rdata", rdat, {24'h0, e});
        chk("rresp", rr, er);
    endtask

    task automatic wait_irq();
        for (int n = 0; n <= 20000; n++) begin
            if (n == 20000) tmo();
            @(posedge aclk);
            if (irq === 1'b1) break;
        end
    endtask

    task automatic t_reset();
        rd(CA, 8'h00, OK);
        rd(DA, 8'h00, OK);
        rd(12'h000, 8'h00, ER);
        wr(12'h004, 8'hff, ER);
    endtask

    // queued byte, overwrite while full, overwrite of unread receive byte
    task automatic t_master();
        wr(CA, 8'h10, OK);
        sel_n <= 1'b0;
        rises <= 0;
        wr(DA, 8'ha5, OK);
        wr(DA, 8'h5a, OK);
        rd(CA, 8'h50, OK);
        wr(DA, 8'hc3, OK);
        wait_irq();
        chk("partner rx", sbp_spi_partner_i.rx_sh, 8'ha5);
        rd(CA, 8'h90, OK);
        chk("master sck oe", sck_e, 1'b1);
        chk("master mosi oe", mosi_e, 1'b1);
        wr(CA, 8'h10, OK);
        chk("irq clear", irq, 1'b0);
        wait_irq();
        chk("partner rx", sbp_spi_partner_i.rx_sh, 8'hc3);
        rd(DA, 8'hc3, OK);
        chk("sck pulses", rises, 16);
        chk("sck active", hi, `SBP_BIT_CYC0 / `SBP_DUTY_DIV_FAST);
        sel_n <= 1'b1;
    endtask

    // the slower rates, with polarity toggled
    task automatic t_rates();
        for (int r = 1; r < 4; r++) begin
            wr(CA, {4'h1, r[0], 1'b0, r[1:0]}, OK);
            clock_polarity_sel_cur <= r[0];
            @(posedge aclk);
            rises <= 0;
            chk("sck idle", sck_o, r[0]);
            wr(DA, 8'h00, OK);
            wait_irq();
            chk("sck pulses", rises, 8);
            chk("sck active", hi, cyc[r] / `SBP_DUTY_DIV);
        end
    endtask

    task automatic t_slave();
        wr(CA, 8'h20, OK);
        wr(DA, 8'h81, OK);
        rd(CA, 8'h60, OK);
        sbp_spi_partner_i.send(8'h5a, 8, got);
        chk("slave tx", got, 8'h81);
        wait_irq();
        rd(DA, 8'h5a, OK);
        wr(CA, 8'h20, OK);
        sbp_spi_partner_i.send(8'hff, 3, got);
        repeat (20) @(posedge aclk);
        chk("abort irq", irq, 1'b0);
    endtask

    // disabled: nothing driven, nothing completes
    task automatic t_off();
        wr(CA, 8'h00, OK);
        sbp_spi_partner_i.send(8'hff, 8, got);
        repeat (20) @(posedge aclk);
        chk("off irq", irq, 1'b0);
        chk("off sck oe", sck_e, 1'b0);
        chk("off miso oe", miso_e, 1'b0);
        chk("off mosi oe", mosi_e, 1'b0);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_master();
        t_rates();
        t_slave();
        t_off();
        results();
    end
endmodule // test_spi_master_slave_byte_port
